//--- design/cwf_db_if.sv
`timescale 1ns/1ps
interface cwf_db_if;
	import cwf_pkg::*;
	logic       x;
	logic       tick;
	cwf_count_t count;
	logic       y;
	modport gen   (output x, output tick, output count, input y);
	modport timer (input x, input tick, input count, output y);
endinterface : cwf_db_if

//--- design/cwf_deadband.sv
`timescale 1ns/1ps
module cwf_deadband
	import cwf_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Timer link
	cwf_db_if.timer   db
);

	typedef struct packed {
		cwf_count_t cnt;
	} cwf_db_state_s;

	cwf_db_state_s s_q;
	cwf_db_state_s s_d;

	always_comb begin
		s_d = s_q;
		if (!db.x) begin
			s_d.cnt = '0;
		end else if (db.tick && (s_q.cnt < db.count)) begin
			s_d.cnt = s_q.cnt + cwf_count_t'(1);
		end
	end

	// Turn-on waits for the count; turn-off is never delayed
	assign db.y = db.x && (s_q.cnt >= db.count);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence start_delay;
		$rose(db.x) && (db.count != '0);
	endsequence

	db_off_a: assert property (!db.x |-> !db.y) else $error("timer output high with input low");
	db_delay_a: assert property (start_delay |-> !db.y) else $error("no dead band on delayed edge");

endmodule : cwf_deadband

//--- design/cwf_defines.svh
`ifndef CWF_DEFINES_SVH
`define CWF_DEFINES_SVH

// Register offsets inside one unit window
`define CWF_OFF_CTRL0     5'h00
`define CWF_OFF_CTRL1     5'h04
`define CWF_OFF_DBAND     5'h08
`define CWF_OFF_ASHUT     5'h0c
`define CWF_OFF_STEER     5'h10
`define CWF_OFF_STATUS    5'h14
`define CWF_UNIT_LSB      5

// Field positions
`define CWF_C0_MODE_LSB   0
`define CWF_C0_EN_BIT     7
`define CWF_C0_ISM_LSB    8
`define CWF_C0_CS_BIT     12
`define CWF_C1_POL_LSB    0
`define CWF_DB_RISE_LSB   0
`define CWF_DB_FALL_LSB   8
`define CWF_DB_RISE_EN    16
`define CWF_DB_FALL_EN    17
`define CWF_AS_MASK_LSB   0
`define CWF_AS_REN_BIT    6
`define CWF_AS_SHDN_BIT   7
`define CWF_AS_OVR_LSB    8
`define CWF_ST_STR_LSB    0
`define CWF_ST_SOVR_LSB   4
`define CWF_SR_SHDN_BIT   0
`define CWF_SR_OUT_LSB    4
`define CWF_SR_DIR_BIT    8
`define CWF_SR_SEQ_BIT    9

// Reset values and bus answers
`define CWF_RST_FIELD     1'b0
`define CWF_RST_SEQ       1'b1
`define CWF_RESP_OKAY     2'b00
`define CWF_RESP_SLVERR   2'b10

// Timing
`define CWF_DB_WIDTH      6

`endif

//--- design/cwf_gen.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Six modes chosen by mode field
// - One data input, four outputs A-D
// - Dead time delays half-bridge and push-pull turn-on, and the full-bridge modulated leg
// - Two independent 6-bit dead-band timers
// - Separate rising and falling dead-band enables
// - Auto-shutdown: sources, restart, override levels
// - Half-bridge: A true, B inverted
// - Half-bridge outputs never both active
// - Steering ignored in half-bridge
// - Half-bridge C, D follow A, B
// - Push-pull alternates pulses between A, B
// - Steering ignored in push-pull
// - Sequencer resets on disable or shutdown
// - First pulse after reset goes to A
// - Push-pull C, D copy A, B
// - Full-bridge: three static, one modulated
// - Direction toggle allowed while enabled
// - Forward: A active, D modulated
// - Reverse: C active, B modulated
// - Independent polarity per output
// - Two independent generator copies
// - Direction change on next data rise
// - Full-bridge dead band only on enable and on turnaround
// - Mode 000 async, 001 sync steering
// - Polarity set is active-high; overrides raw
module cwf_gen
	import cwf_pkg::*;
#(
	parameter int NUM_UNITS = 2,
	parameter int NUM_SRC   = 16,
	parameter int NUM_SHDN  = 4
) (
	// Clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   nrst_i,
	// Pulse sources and shutdown sources
	input  wire logic [NUM_SRC-1:0]     data_src_i,
	input  wire logic [NUM_SHDN-1:0]    shutdown_src_i,
	input  wire logic                   fast_osc_tick_i,
	// AXI4-Lite slave
	input  wire logic [7:0]             s_axi_awaddr_i,
	input  wire logic                   s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	input  wire logic [31:0]            s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	input  wire logic                   s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	output logic [1:0]                  s_axi_bresp_o,
	output logic                        s_axi_bvalid_o,
	input  wire logic                   s_axi_bready_i,
	input  wire logic [7:0]             s_axi_araddr_i,
	input  wire logic                   s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	output logic [31:0]                 s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	output logic                        s_axi_rvalid_o,
	input  wire logic                   s_axi_rready_i,
	// Bridge outputs, four per unit: A at bit 0 up to D at bit 3
	output logic [NUM_UNITS*4-1:0]      bridge_output_o
);

	typedef struct packed {
		logic                       awready;
		logic                       wready;
		logic                       aw_have;
		logic                       w_have;
		logic [7:0]                 awaddr;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		cwf_unit_s [NUM_UNITS-1:0]  u;
	} cwf_state_s;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic cwf_hit(input logic [7:0] addr);
		logic [4:0] off;
		off = addr[4:0];
		return (int'(addr[7:`CWF_UNIT_LSB]) < NUM_UNITS) &&
			(off == `CWF_OFF_CTRL0 || off == `CWF_OFF_CTRL1 || off == `CWF_OFF_DBAND ||
			 off == `CWF_OFF_ASHUT || off == `CWF_OFF_STEER || off == `CWF_OFF_STATUS);
	endfunction : cwf_hit

	function automatic logic [31:0] cwf_read(input cwf_unit_s u, input logic [4:0] off);
		logic [31:0] w;
		w = '0;
		case (off)
			`CWF_OFF_CTRL0: begin
				w[`CWF_C0_MODE_LSB +: 3] = u.mode;
				w[`CWF_C0_EN_BIT]        = u.en;
				w[`CWF_C0_ISM_LSB +: 4]  = u.ism;
				w[`CWF_C0_CS_BIT]        = u.cs;
			end
			`CWF_OFF_CTRL1: w[`CWF_C1_POL_LSB +: 4] = u.pol;
			`CWF_OFF_DBAND: begin
				w[`CWF_DB_RISE_LSB +: `CWF_DB_WIDTH] = u.dbr;
				w[`CWF_DB_FALL_LSB +: `CWF_DB_WIDTH] = u.dbf;
				w[`CWF_DB_RISE_EN]                   = u.dbr_en;
				w[`CWF_DB_FALL_EN]                   = u.dbf_en;
			end
			`CWF_OFF_ASHUT: begin
				w[`CWF_AS_MASK_LSB +: 4] = u.as_mask;
				w[`CWF_AS_REN_BIT]       = u.restart;
				w[`CWF_AS_SHDN_BIT]      = u.shdn;
				w[`CWF_AS_OVR_LSB +: 4]  = u.ovr;
			end
			`CWF_OFF_STEER: begin
				w[`CWF_ST_STR_LSB +: 4]  = u.str;
				w[`CWF_ST_SOVR_LSB +: 4] = u.sovr;
			end
			`CWF_OFF_STATUS: begin
				w[`CWF_SR_SHDN_BIT]     = u.shdn;
				w[`CWF_SR_OUT_LSB +: 4] = u.out;
				w[`CWF_SR_DIR_BIT]      = u.dir;
				w[`CWF_SR_SEQ_BIT]      = u.pp_sel;
			end
			default: w = '0;
		endcase
		return w;
	endfunction : cwf_read

	function automatic logic [31:0] cwf_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return m;
	endfunction : cwf_merge

	function automatic logic cwf_din(input cwf_unit_s u, input logic [NUM_SRC-1:0] src);
		return src[u.ism];
	endfunction : cwf_din

	function automatic logic cwf_is_fb(input cwf_unit_s u);
		return u.mode == MODE_FB_FWD || u.mode == MODE_FB_REV;
	endfunction : cwf_is_fb

	////////////////////////////////////////////////////////////////////////
	// Reset release and state

	logic [1:0]   rst_sync_q;
	logic         rst_n;
	cwf_state_s   s_q;
	cwf_state_s   s_d;
	logic [NUM_UNITS*2-1:0] db_x;
	logic [NUM_UNITS*2-1:0] db_tick;
	cwf_count_t   db_count [NUM_UNITS*2];
	logic [NUM_UNITS*2-1:0] db_y;
	logic [3:0]   act_c [NUM_UNITS];
	logic [NUM_UNITS-1:0] dir_now_c;
	logic [NUM_UNITS-1:0] rise_c;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// Dead-band timers, rising then falling per unit

	always_comb begin
		for (int i = 0; i < NUM_UNITS; i++) begin
			cwf_unit_s u;
			logic      din;
			logic      rise;
			logic      turn;
			u    = s_q.u[i];
			din  = cwf_din(u, data_src_i);
			rise = din && !u.din_prev;
			turn = cwf_is_fb(u) && rise && (u.mode[0] != u.dir);
			rise_c[i] = rise;
			// A turnaround drops the timer input for one cycle so it restarts
			case (u.mode)
				MODE_HALF, MODE_PUSH_PULL: db_x[2*i] = u.en && din;
				MODE_FB_FWD, MODE_FB_REV:  db_x[2*i] = u.en && !turn;
				default:                   db_x[2*i] = 1'b0;
			endcase
			db_x[2*i+1]     = u.en && (u.mode == MODE_HALF) && !din;
			db_count[2*i]   = u.dbr_en ? u.dbr : cwf_count_t'(0);
			db_count[2*i+1] = u.dbf_en ? u.dbf : cwf_count_t'(0);
			db_tick[2*i]    = u.cs ? fast_osc_tick_i : 1'b1;
			db_tick[2*i+1]  = u.cs ? fast_osc_tick_i : 1'b1;
		end
	end

	for (genvar g = 0; g < NUM_UNITS*2; g++) begin : g_db
		cwf_db_if dbi ();
		assign dbi.x     = db_x[g];
		assign dbi.tick  = db_tick[g];
		assign dbi.count = db_count[g];
		assign db_y[g]   = dbi.y;
		cwf_deadband u_db (
			.clk_i   (clk_sys_i),
			.rst_n_i (rst_n),
			.db      (dbi)
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave and waveform logic

	always_comb begin
		logic [4:0]  off;
		logic [2:0]  un;
		logic [31:0] m;
		s_d = s_q;
		off = s_q.awaddr[4:0];
		un  = s_q.awaddr[7:`CWF_UNIT_LSB];
		m   = '0;
		if (s_axi_awvalid_i && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr_i;
			s_d.awready = 1'b0;
		end
		if (s_axi_wvalid_i && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata_i;
			s_d.wstrb  = s_axi_wstrb_i;
			s_d.wready = 1'b0;
		end
		if (s_q.bvalid && s_axi_bready_i) begin
			s_d.bvalid  = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = cwf_hit(s_q.awaddr) ? `CWF_RESP_OKAY : `CWF_RESP_SLVERR;
			if (cwf_hit(s_q.awaddr)) begin
				m = cwf_merge(cwf_read(s_q.u[un], off), s_q.wdata, s_q.wstrb);
				case (off)
					`CWF_OFF_CTRL0: begin
						// Mode may be rewritten while enabled; only the direction bit is meant to move
						s_d.u[un].mode = cwf_mode_e'(m[`CWF_C0_MODE_LSB +: 3]);
						s_d.u[un].en   = m[`CWF_C0_EN_BIT];
						s_d.u[un].ism  = m[`CWF_C0_ISM_LSB +: 4];
						s_d.u[un].cs   = m[`CWF_C0_CS_BIT];
					end
					`CWF_OFF_CTRL1: s_d.u[un].pol = m[`CWF_C1_POL_LSB +: 4];
					`CWF_OFF_DBAND: begin
						s_d.u[un].dbr    = m[`CWF_DB_RISE_LSB +: `CWF_DB_WIDTH];
						s_d.u[un].dbf    = m[`CWF_DB_FALL_LSB +: `CWF_DB_WIDTH];
						s_d.u[un].dbr_en = m[`CWF_DB_RISE_EN];
						s_d.u[un].dbf_en = m[`CWF_DB_FALL_EN];
					end
					`CWF_OFF_ASHUT: begin
						s_d.u[un].as_mask = m[`CWF_AS_MASK_LSB +: 4];
						s_d.u[un].restart = m[`CWF_AS_REN_BIT];
						s_d.u[un].shdn    = m[`CWF_AS_SHDN_BIT];
						s_d.u[un].ovr     = m[`CWF_AS_OVR_LSB +: 4];
					end
					`CWF_OFF_STEER: begin
						s_d.u[un].str  = m[`CWF_ST_STR_LSB +: 4];
						s_d.u[un].sovr = m[`CWF_ST_SOVR_LSB +: 4];
					end
					default: m = '0;
				endcase
			end
		end
		if (s_axi_arvalid_i && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rresp   = cwf_hit(s_axi_araddr_i) ? `CWF_RESP_OKAY : `CWF_RESP_SLVERR;
			s_d.rdata   = cwf_hit(s_axi_araddr_i) ?
				cwf_read(s_q.u[s_axi_araddr_i[7:`CWF_UNIT_LSB]], s_axi_araddr_i[4:0]) : 32'h0;
		end
		if (s_q.rvalid && s_axi_rready_i) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end

		for (int i = 0; i < NUM_UNITS; i++) begin
			cwf_unit_s  u;
			logic       din;
			logic       trip;
			logic       shut;
			logic       sel;
			logic       dir;
			logic [3:0] str;
			logic [3:0] act;
			logic [3:0] o;
			logic       ry;
			logic       fy;
			sel  = 1'b0;
			dir  = 1'b0;
			str  = 4'h0;
			act  = 4'h0;
			o    = 4'h0;
			u    = s_q.u[i];
			din  = cwf_din(u, data_src_i);
			trip = u.en && |(shutdown_src_i & u.as_mask[NUM_SHDN-1:0]);
			shut = u.shdn || trip;
			ry   = db_y[2*i];
			fy   = db_y[2*i+1];
			s_d.u[i].din_prev = din;
			// Hardware set comes after the register write so it wins
			if (trip) begin
				s_d.u[i].shdn = 1'b1;
			end else if (u.shdn && u.restart) begin
				s_d.u[i].shdn = 1'b0;
			end
			sel = rise_c[i] ? !u.pp_sel : u.pp_sel;
			if (!u.en || shut) begin
				s_d.u[i].pp_sel = `CWF_RST_SEQ;
			end else if (rise_c[i] && u.mode == MODE_PUSH_PULL) begin
				s_d.u[i].pp_sel = !u.pp_sel;
			end
			dir = (!u.en || (cwf_is_fb(u) && rise_c[i])) ? u.mode[0] : u.dir;
			s_d.u[i].dir = dir;
			dir_now_c[i] = dir;
			str = (u.mode == MODE_STEER_ASYNC || rise_c[i]) ? u.str : u.str_eff;
			s_d.u[i].str_eff = str;
			case (u.mode)
				MODE_HALF:      act = {fy, ry, fy, ry};
				MODE_PUSH_PULL: act = {ry && sel, ry && !sel, ry && sel, ry && !sel};
				MODE_FB_FWD, MODE_FB_REV: begin
					// Static legs switch at once; only the modulated leg waits
					act = dir ? {1'b0, 1'b1, din && ry, 1'b0} : {din && ry, 1'b0, 1'b0, 1'b1};
				end
				default:        act = {4{din}};
			endcase
			act_c[i] = act;
			o = act ^ ~u.pol;
			if (u.mode == MODE_STEER_ASYNC || u.mode == MODE_STEER_SYNC) begin
				o = (o & str) | (u.sovr & ~str);
				if (shut) begin
					o = (u.ovr & str) | (o & ~str);
				end
			end else if (u.mode == MODE_RSVD6 || u.mode == MODE_RSVD7) begin
				o = ~u.pol;
			end else if (shut) begin
				o = u.ovr;
			end
			if (!u.en) begin
				o = ~u.pol;
			end
			s_d.u[i].out = o;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
				u: {NUM_UNITS{CWF_UNIT_RST}}, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready_o = s_q.awready;
	assign s_axi_wready_o  = s_q.wready;
	assign s_axi_bvalid_o  = s_q.bvalid;
	assign s_axi_bresp_o   = s_q.bresp;
	assign s_axi_arready_o = s_q.arready;
	assign s_axi_rvalid_o  = s_q.rvalid;
	assign s_axi_rdata_o   = s_q.rdata;
	assign s_axi_rresp_o   = s_q.rresp;
	for (genvar i = 0; i < NUM_UNITS; i++) begin : g_out
		assign bridge_output_o[4*i +: 4] = s_q.u[i].out;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on unit 0

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	sequence pp_armed;
		s_q.u[0].en && s_q.u[0].mode == MODE_PUSH_PULL && s_q.u[0].pp_sel;
	endsequence

	idle_outputs_a: assert property (!s_q.u[0].en |=> s_q.u[0].out == ~$past(s_q.u[0].pol))
		else $error("disabled unit drives active level");
	half_overlap_a: assert property (s_q.u[0].mode == MODE_HALF |-> !(act_c[0][0] && act_c[0][1]))
		else $error("half-bridge outputs overlap");
	pp_first_a: assert property (pp_armed ##0 rise_c[0] |-> !act_c[0][1] && !act_c[0][3])
		else $error("first push-pull pulse not on A");
	pp_reset_a: assert property (!s_q.u[0].en |=> s_q.u[0].pp_sel)
		else $error("sequencer not reset while disabled");
	fb_forward_a: assert property (cwf_is_fb(s_q.u[0]) && !dir_now_c[0]
		|-> act_c[0][0] && !act_c[0][1] && !act_c[0][2]) else $error("forward static legs wrong");
	fb_reverse_a: assert property (cwf_is_fb(s_q.u[0]) && dir_now_c[0]
		|-> act_c[0][2] && !act_c[0][0] && !act_c[0][3]) else $error("reverse static legs wrong");
	dir_hold_a: assert property (s_q.u[0].en && cwf_is_fb(s_q.u[0]) && !rise_c[0]
		|=> s_q.u[0].dir == $past(s_q.u[0].dir)) else $error("direction changed off data edge");
	shut_override_a: assert property (s_q.u[0].en && s_q.u[0].shdn && s_q.u[0].mode[2:1] != 2'h0
		&& s_q.u[0].mode[2:1] != 2'h3 |=> s_q.u[0].out == $past(s_q.u[0].ovr)) else $error("override not applied");
	axi_write_a: assert property (s_q.aw_have && s_q.w_have && !s_q.bvalid |=> s_q.bvalid ##0 !s_q.awready)
		else $error("write response missing");

endmodule : cwf_gen

//--- design/cwf_pkg.sv
package cwf_pkg;

	`include "cwf_defines.svh"

	typedef enum logic [2:0] {
		MODE_STEER_ASYNC = 3'b000,
		MODE_STEER_SYNC  = 3'b001,
		MODE_FB_FWD      = 3'b010,
		MODE_FB_REV      = 3'b011,
		MODE_HALF        = 3'b100,
		MODE_PUSH_PULL   = 3'b101,
		MODE_RSVD6       = 3'b110,
		MODE_RSVD7       = 3'b111
	} cwf_mode_e;

	typedef logic [`CWF_DB_WIDTH-1:0] cwf_count_t;

	typedef struct packed {
		logic       en;
		cwf_mode_e  mode;
		logic [3:0] ism;
		logic       cs;
		logic [3:0] pol;
		cwf_count_t dbr;
		cwf_count_t dbf;
		logic       dbr_en;
		logic       dbf_en;
		logic [3:0] as_mask;
		logic       restart;
		logic [3:0] ovr;
		logic [3:0] str;
		logic [3:0] sovr;
		logic       shdn;
		logic       din_prev;
		logic       pp_sel;
		logic       dir;
		logic [3:0] str_eff;
		logic [3:0] out;
	} cwf_unit_s;

	localparam cwf_unit_s CWF_UNIT_RST = '{
		mode:    MODE_STEER_ASYNC,
		pp_sel:  `CWF_RST_SEQ,
		default: `CWF_RST_FIELD
	};

endpackage : cwf_pkg

//--- tb/cwf_bridge_model.sv
`timescale 1ns/1ps
module cwf_bridge_model (
	// Clock and arming
	input  wire logic       clk_i,
	input  wire logic       arm_i,
	// Pin levels and the polarity they are read with
	input  wire logic [3:0] pol_i,
	input  wire logic [3:0] pins_i,
	// Shoot-through count
	output int              overlap_o
);
	logic [3:0] on_w;

	// A switch conducts when its pin sits at its active level
	assign on_w = ~(pins_i ^ pol_i);

	initial overlap_o = 0;

	// Legs pair A with B and C with D; both on shorts the supply
	always @(posedge clk_i) begin
		if (arm_i && ((on_w[0] && on_w[1]) || (on_w[2] && on_w[3]))) begin
			overlap_o <= overlap_o + 1;
		end
	end
endmodule : cwf_bridge_model

//--- tb/cwf_gen_tb.sv
`timescale 1ns/1ps
`include "cwf_defines.svh"
module cwf_gen_tb;
	import cwf_pkg::*;

	typedef struct {
		string       nm;
		logic [33:0] v;
	} cwf_note_s;

	localparam logic [7:0] A_C0 = 8'(`CWF_OFF_CTRL0);
	localparam logic [7:0] A_C1 = 8'(`CWF_OFF_CTRL1);
	localparam logic [7:0] A_DB = 8'(`CWF_OFF_DBAND);
	localparam logic [7:0] A_AS = 8'(`CWF_OFF_ASHUT);
	localparam logic [7:0] A_ST = 8'(`CWF_OFF_STEER);
	localparam logic [1:0] OK   = `CWF_RESP_OKAY;
	localparam logic [1:0] ERR  = `CWF_RESP_SLVERR;

	logic        clk_sys_i       = 1'b0;
	logic        nrst_i          = 1'b0;
	logic [15:0] data_src_i      = '0;
	logic [3:0]  shutdown_src_i  = '0;
	logic        fast_osc_tick_i = 1'b0;
	logic [7:0]  awaddr          = '0;
	logic [7:0]  araddr          = '0;
	logic [31:0] wdata           = '0;
	logic        awvalid         = 1'b0;
	logic        wvalid          = 1'b0;
	logic        bready          = 1'b0;
	logic        arvalid         = 1'b0;
	logic        rready          = 1'b0;
	logic        smp             = 1'b0;
	logic        arm             = 1'b0;
	logic [3:0]  pol             = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  pins;
	int          overlap;
	int          n_fail          = 0;
	int          n_checks        = 0;
	int          cyc             = 0;
	cwf_mode_e   cur             = MODE_STEER_ASYNC;
	cwf_note_s   notes[$];

	always #4 clk_sys_i = ~clk_sys_i;

	cwf_gen cwf_gen_inst (
		.clk_sys_i       (clk_sys_i),
		.nrst_i          (nrst_i),
		.data_src_i      (data_src_i),
		.shutdown_src_i  (shutdown_src_i),
		.fast_osc_tick_i (fast_osc_tick_i),
		.s_axi_awaddr_i  (awaddr),
		.s_axi_awvalid_i (awvalid),
		.s_axi_awready_o (awready),
		.s_axi_wdata_i   (wdata),
		.s_axi_wstrb_i   (4'hf),
		.s_axi_wvalid_i  (wvalid),
		.s_axi_wready_o  (wready),
		.s_axi_bresp_o   (bresp),
		.s_axi_bvalid_o  (bvalid),
		.s_axi_bready_i  (bready),
		.s_axi_araddr_i  (araddr),
		.s_axi_arvalid_i (arvalid),
		.s_axi_arready_o (arready),
		.s_axi_rdata_o   (rdata),
		.s_axi_rresp_o   (rresp),
		.s_axi_rvalid_o  (rvalid),
		.s_axi_rready_i  (rready),
		.bridge_output_o (pins)
	);

	cwf_bridge_model cwf_bridge_model_inst (
		.clk_i     (clk_sys_i),
		.arm_i     (arm),
		.pol_i     (pol),
		.pins_i    (pins[3:0]),
		.overlap_o (overlap)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic pop(input logic [33:0] got);
		cwf_note_s n;
		if (notes.size() == 0) begin
			n_fail++;
			$display("[FAIL] unasked result expected none seen %h", got);
		end else begin
			n = notes.pop_front();
			check(n.nm, n.v, got);
		end
	endtask : pop

	// Results are matched in order against what the driver noted
	always @(posedge clk_sys_i) begin
		if (rvalid === 1'b1 && rready) pop({rresp, rdata});
		if (bvalid === 1'b1 && bready) pop({32'h0, bresp});
		if (smp) pop({26'h0, pins});
	end

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unselected sources and the fast tick carry noise the unit must ignore
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			fast_osc_tick_i <= 1'($urandom);
			data_src_i[15:1] <= 15'($urandom);
		end
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
		logic aw_d;
		logic w_d;
		notes.push_back('{"bresp", {32'h0, rsp}});
		aw_d = 1'b0;
		w_d = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_d && w_d)) begin
			step(1);
			if (!aw_d && awready === 1'b1) begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_d && wready === 1'b1) begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do step(1); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		notes.push_back('{"rdata", e});
		araddr <= a;
		arvalid <= 1'b1;
		do step(1); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do step(1); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask : rd

	// Unit 1 stays disabled with polarity clear, so its pins sit high
	task automatic chk(input logic v, input int w, input logic [3:0] nib, input string nm);
		data_src_i[0] <= v;
		step(w);
		notes.push_back('{nm, {26'h0, 4'hf, nib}});
		smp <= 1'b1;
		step(1);
		smp <= 1'b0;
	endtask : chk

	function automatic logic [31:0] c0(input cwf_mode_e m, input logic en);
		return {19'h0, 1'b0, 4'h0, en, 4'h0, m};
	endfunction : c0

	// Mode moves only with the unit disabled
	task automatic setmode(input cwf_mode_e m);
		wr(A_C0, c0(cur, 1'b0), OK);
		wr(A_C0, c0(m, 1'b0), OK);
		wr(A_C0, c0(m, 1'b1), OK);
		cur = m;
	endtask : setmode

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(66));
		step(6);
		nrst_i <= 1'b1;
		step(4);
		chk(0, 3, 4'hf, "disabled pins");
		wr(A_C1, 32'h5, OK);
		chk(0, 3, 4'ha, "inactive levels");
		rd(A_C1, {OK, 32'h5});
		rd(8'h18, {ERR, 32'h0});
		wr(8'h18, 32'h1, ERR);
		wr(A_C1, 32'hf, OK);
		pol <= 4'hf;
		chk(0, 3, 4'h0, "inactive high pol");
		arm <= 1'b1;
		setmode(MODE_FB_FWD);
		chk(0, 3, 4'b0001, "fwd low");
		chk(1, 3, 4'b1001, "fwd high");
		wr(A_C0, c0(MODE_FB_REV, 1'b1), OK);
		cur = MODE_FB_REV;
		chk(0, 3, 4'b0001, "before rise");
		chk(1, 3, 4'b0110, "rev high");
		chk(0, 3, 4'b0100, "rev low");
		wr(A_ST, 32'hf0, OK);
		setmode(MODE_HALF);
		chk(1, 3, 4'b0101, "half high");
		chk(0, 3, 4'b1010, "half low");
		wr(A_DB, 32'h0001_0004, OK);
		chk(1, 1, 4'b0000, "rise dead band");
		chk(1, 6, 4'b0101, "after dead band");
		chk(0, 1, 4'b1010, "fall undelayed");
		wr(A_DB, 32'h0, OK);
		wr(A_AS, 32'h0000_0601, OK);
		shutdown_src_i <= 4'h1;
		chk(1, 3, 4'b0110, "override");
		shutdown_src_i <= 4'h0;
		wr(A_AS, 32'h0000_0601, OK);
		chk(1, 3, 4'b0101, "cleared");
		wr(A_AS, 32'h0000_0641, OK);
		shutdown_src_i <= 4'h1;
		chk(1, 3, 4'b0110, "restart hold");
		shutdown_src_i <= 4'h0;
		chk(1, 4, 4'b0101, "auto restart");
		setmode(MODE_PUSH_PULL);
		chk(0, 3, 4'b0000, "pp idle");
		chk(1, 3, 4'b0101, "pp first");
		chk(0, 3, 4'b0000, "pp gap");
		chk(1, 3, 4'b1010, "pp second");
		chk(0, 3, 4'b0000, "pp gap");
		shutdown_src_i <= 4'h1;
		step(3);
		shutdown_src_i <= 4'h0;
		// Let auto-restart clear first so the next rise is not swallowed by shutdown
		chk(0, 3, 4'b0000, "pp restarted");
		chk(1, 5, 4'b0101, "pp after shutdown");
		chk(0, 3, 4'b0000, "pp gap");
		setmode(MODE_PUSH_PULL);
		chk(1, 3, 4'b0101, "pp after disable");
		wr(A_ST, 32'h41, OK);
		for (int m = 0; m < 2; m++) begin
			setmode(cwf_mode_e'(m));
			chk(1, 3, 4'b0101, "steer high");
			chk(0, 3, 4'b0100, "steer low");
		end
		// Synchronous steering: a new selection waits for the next data rise
		chk(1, 3, 4'b0101, "sync high");
		wr(A_ST, 32'h02, OK);
		chk(1, 3, 4'b0001, "sync held");
		chk(0, 3, 4'b0000, "sync low");
		chk(1, 3, 4'b0010, "sync applied");
		setmode(MODE_RSVD6);
		chk(1, 3, 4'b0000, "reserved idle");
		check("overlap", 34'h0, 34'(overlap));
		stop_test();
	end
endmodule : cwf_gen_tb
